// *** decode_if.sv ***
`timescale 1ns/1ps
interface decode_if;
    logic [13:0] insn;
    logic is_return;
    logic is_rot_right;
    logic is_rot_left;
    logic is_sleep;
    logic [6:0] file_addr;
    logic dest;

    modport dec (
        input insn,
        output is_return, is_rot_right, is_rot_left, is_sleep, file_addr, dest
    );
    modport core (
        output insn,
        input is_return, is_rot_right, is_rot_left, is_sleep, file_addr, dest
    );
endinterface

// *** exec_pkg.sv ***
package exec_pkg;

    localparam logic [13:0] OPC_RETURN = 14'h0008;
    localparam logic [13:0] OPC_SLEEP = 14'h0063;
    localparam logic [5:0] OPC_ROT_RIGHT = 6'h0c;
    localparam logic [5:0] OPC_ROT_LEFT = 6'h0d;
    localparam int OPC_HI = 13;
    localparam int OPC_LO = 8;
    localparam int DEST_BIT = 7;
    localparam int FADDR_W = 7;

    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] STATUS_ADDR = 8'h04;
    localparam logic [7:0] WREG_ADDR = 8'h08;

    localparam int CTRL_EN = 0;
    localparam int CTRL_WAKE = 1;
    localparam int STAT_SLEEP = 0;
    localparam int STAT_TMO = 1;
    localparam int STAT_PDN = 2;
    localparam int STAT_CARRY = 3;
    localparam int STAT_RETP = 4;

    localparam logic CTRL_EN_RST = 1'b1;
    localparam logic TMO_RST = 1'b1;
    localparam logic PDN_RST = 1'b1;
    localparam logic [7:0] WREG_RST = 8'h00;

    localparam int CYCLE_DIV = 4;

endpackage

// *** insn_decoder.sv ***
`timescale 1ns/1ps
module insn_decoder
    import exec_pkg::*;
(
    decode_if.dec dif
);

    always_comb begin
        dif.is_return = (dif.insn == OPC_RETURN);
        dif.is_sleep = (dif.insn == OPC_SLEEP);
        dif.is_rot_right = (dif.insn[OPC_HI:OPC_LO] == OPC_ROT_RIGHT);
        dif.is_rot_left = (dif.insn[OPC_HI:OPC_LO] == OPC_ROT_LEFT);
        dif.file_addr = dif.insn[FADDR_W-1:0];
        dif.dest = dif.insn[DEST_BIT];
    end

endmodule // insn_decoder

// *** return_rotate_sleep_exec.sv ***
// The address map and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps
module return_rotate_sleep_exec
    import exec_pkg::*;
#(
    parameter int PC_W = 13,
    parameter int DIV = CYCLE_DIV
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    input wire logic [13:0] insn_i,
    input wire logic insn_valid_i,
    input wire logic [PC_W-1:0] tos_i,
    output logic [6:0] file_raddr_o,
    input wire logic [7:0] file_rdata_i,
    output logic file_we_o,
    output logic [6:0] file_waddr_o,
    output logic [7:0] file_wdata_o,
    output logic [7:0] working_reg_o,
    output logic carry_o,
    output logic stack_pop_o,
    output logic pc_load_o,
    output logic [PC_W-1:0] program_counter_o,
    output logic flush_o,
    output logic wdt_clear_o,
    output logic timeout_flag_o,
    output logic powerdown_flag_o,
    output logic sleep_o,
    output logic cycle_en_o,
    output logic busy_o
);

    localparam int DIV_W = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV - 1);

    typedef struct packed {
        logic [DIV_W-1:0] div;
        logic en;
        logic sleeping;
        logic timeout_flag;
        logic powerdown_flag;
        logic carry;
        logic [7:0] working_reg;
        logic ret_pend;
        logic pc_load;
        logic pop;
        logic flush;
        logic [PC_W-1:0] program_counter;
        logic file_we;
        logic [6:0] waddr;
        logic [7:0] wdata;
        logic wdt_clr;
        logic bus_act;
        logic bus_wr;
        logic [7:0] bus_addr;
        logic [31:0] rdata;
    } state_type;

    state_type s_q;
    state_type s_d;
    logic cyc_en;
    logic [7:0] rot_res;
    logic rot_carry;

    decode_if dif ();

    assign dif.insn = insn_i;

    insn_decoder u_dec (
        .dif(dif)
    );

    // Register read view, shared by the bus address phase.
    function automatic logic [31:0] reg_read(input logic [7:0] a,
                                             input state_type s);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (a)
            CTRL_ADDR: begin
                v[CTRL_EN] = s.en;
            end
            STATUS_ADDR: begin
                v[STAT_SLEEP] = s.sleeping;
                v[STAT_TMO] = s.timeout_flag;
                v[STAT_PDN] = s.powerdown_flag;
                v[STAT_CARRY] = s.carry;
                v[STAT_RETP] = s.ret_pend;
            end
            WREG_ADDR: begin
                v[7:0] = s.working_reg;
            end
            default: begin
                v = 32'h0000_0000;
            end
        endcase
        return v;
    endfunction

    // Rotate through carry: the old carry fills the vacated end.
    always_comb begin
        rot_res = 8'h00;
        rot_carry = s_q.carry;
        if (dif.is_rot_right) begin
            rot_res = {s_q.carry, file_rdata_i[7:1]};
            rot_carry = file_rdata_i[0];
        end else if (dif.is_rot_left) begin
            rot_res = {file_rdata_i[6:0], s_q.carry};
            rot_carry = file_rdata_i[7];
        end
    end

    always_comb begin
        s_d = s_q;
        s_d.pc_load = 1'b0;
        s_d.pop = 1'b0;
        s_d.flush = 1'b0;
        s_d.file_we = 1'b0;
        s_d.wdt_clr = 1'b0;
        cyc_en = (s_q.div == DIV_LAST);
        s_d.div = cyc_en ? '0 : s_q.div + DIV_W'(1);

        // Data phase of a bus write.
        if (s_q.bus_act && s_q.bus_wr) begin
            case (s_q.bus_addr)
                CTRL_ADDR: begin
                    s_d.en = hwdata_i[CTRL_EN];
                    if (hwdata_i[CTRL_WAKE]) begin
                        s_d.sleeping = 1'b0;
                    end
                end
                STATUS_ADDR: begin
                    s_d.carry = hwdata_i[STAT_CARRY];
                end
                WREG_ADDR: begin
                    s_d.working_reg = hwdata_i[7:0];
                end
                default: begin
                end
            endcase
        end

        // Address phase; read data is fixed here and shown next cycle.
        s_d.bus_act = 1'b0;
        if (hsel_i && hready_i && htrans_i[1]) begin
            s_d.bus_act = 1'b1;
            s_d.bus_wr = hwrite_i;
            s_d.bus_addr = haddr_i[7:0];
            if (!hwrite_i) begin
                s_d.rdata = reg_read(haddr_i[7:0], s_q);
            end
        end

        // Execution comes last so that core updates win over bus writes.
        if (cyc_en && s_q.en && !s_q.sleeping) begin
            if (s_q.ret_pend) begin
                s_d.ret_pend = 1'b0;
                s_d.flush = 1'b1;
            end else if (insn_valid_i) begin
                if (dif.is_return) begin
                    s_d.pop = 1'b1;
                    s_d.pc_load = 1'b1;
                    s_d.program_counter = tos_i;
                    s_d.ret_pend = 1'b1;
                end else if (dif.is_rot_right || dif.is_rot_left) begin
                    s_d.carry = rot_carry;
                    if (dif.dest) begin
                        s_d.file_we = 1'b1;
                        s_d.waddr = dif.file_addr;
                        s_d.wdata = rot_res;
                    end else begin
                        s_d.working_reg = rot_res;
                    end
                end else if (dif.is_sleep) begin
                    s_d.wdt_clr = 1'b1;
                    s_d.timeout_flag = 1'b1;
                    s_d.powerdown_flag = 1'b0;
                    s_d.sleeping = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= '0;
            s_q.en <= CTRL_EN_RST;
            s_q.timeout_flag <= TMO_RST;
            s_q.powerdown_flag <= PDN_RST;
            s_q.working_reg <= WREG_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign hrdata_o = s_q.rdata;
    assign file_raddr_o = dif.file_addr;
    assign file_we_o = s_q.file_we;
    assign file_waddr_o = s_q.waddr;
    assign file_wdata_o = s_q.wdata;
    assign working_reg_o = s_q.working_reg;
    assign carry_o = s_q.carry;
    assign stack_pop_o = s_q.pop;
    assign pc_load_o = s_q.pc_load;
    assign program_counter_o = s_q.program_counter;
    assign flush_o = s_q.flush;
    assign wdt_clear_o = s_q.wdt_clr;
    assign timeout_flag_o = s_q.timeout_flag;
    assign powerdown_flag_o = s_q.powerdown_flag;
    assign sleep_o = s_q.sleeping;
    assign cycle_en_o = cyc_en;
    assign busy_o = s_q.ret_pend | s_q.sleeping;

endmodule // return_rotate_sleep_exec

// *** rrs_assertions.sv ***
`timescale 1ns/1ps
module rrs_checker
    import exec_pkg::*;
#(
    parameter int PC_W = 13
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [13:0] insn_i,
    input wire logic [PC_W-1:0] tos_i,
    input wire logic [7:0] file_rdata_i,
    input wire logic file_we_o,
    input wire logic [6:0] file_waddr_o,
    input wire logic [7:0] file_wdata_o,
    input wire logic carry_o,
    input wire logic stack_pop_o,
    input wire logic pc_load_o,
    input wire logic [PC_W-1:0] program_counter_o,
    input wire logic flush_o,
    input wire logic wdt_clear_o,
    input wire logic timeout_flag_o,
    input wire logic powerdown_flag_o,
    input wire logic sleep_o,
    input wire logic cycle_en_o,
    input wire logic busy_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    a_pop_cause: assert property (stack_pop_o |->
        $past(insn_i) == OPC_RETURN && $past(cycle_en_o))
        else $error("pop without return");
    a_pc_load: assert property (stack_pop_o |-> pc_load_o &&
        program_counter_o == $past(tos_i) && carry_o == $past(carry_o))
        else $error("return load wrong");
    a_flush_after: assert property (stack_pop_o |->
        ##[1:9] flush_o) else $error("no flush after return");
    a_flush_cause: assert property (flush_o |->
        $past(busy_o) && !stack_pop_o) else $error("stray flush");
    a_sleep_flags: assert property (wdt_clear_o |-> sleep_o &&
        timeout_flag_o && !powerdown_flag_o && $past(insn_i) == OPC_SLEEP)
        else $error("sleep flags wrong");
    a_write_dest: assert property (file_we_o |->
        $past(insn_i[7]) && file_waddr_o == $past(insn_i[6:0]))
        else $error("file write target wrong");
    a_right_rot: assert property (file_we_o &&
        $past(insn_i[13:8]) == OPC_ROT_RIGHT |-> carry_o == $past(
        file_rdata_i[0]) && file_wdata_o == {$past(carry_o),
        $past(file_rdata_i[7:1])}) else $error("right rotate wrong");
    a_left_rot: assert property (file_we_o &&
        $past(insn_i[13:8]) == OPC_ROT_LEFT |-> carry_o == $past(
        file_rdata_i[7]) && file_wdata_o == {$past(file_rdata_i[6:0]),
        $past(carry_o)}) else $error("left rotate wrong");
endmodule // rrs_checker

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
    import exec_pkg::*;
    logic mclk_i = 0, rst_i = 1, hsel_i = 0, hwrite_i = 0, insn_valid_i = 1;
    logic [31:0] haddr_i = 0, hwdata_i = 0, hrdata_o, rd;
    logic [1:0] htrans_i = 0;
    logic [2:0] hsize_i = 3'h2;
    logic [13:0] insn_i = 0;
    logic [12:0] tos_i = 0, program_counter_o;
    logic [7:0] file_rdata_i = 0, file_wdata_o, working_reg_o;
    logic [6:0] file_raddr_o, file_waddr_o;
    logic hready_i, hreadyout_o, hresp_o, file_we_o, carry_o, stack_pop_o;
    logic pc_load_o, flush_o, wdt_clear_o, timeout_flag_o, powerdown_flag_o;
    logic sleep_o, cycle_en_o, busy_o;
    int err_count = 0, tests_run = 0;
    assign hready_i = hreadyout_o;
    return_rotate_sleep_exec #(.DIV(2)) dut (.*);
    always #12.5 mclk_i = ~mclk_i;

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wrap_up();
        if (err_count == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic ahb(input logic wr, input logic [31:0] a, wd);
        @(posedge mclk_i);
        hsel_i <= 1'b1;
        htrans_i <= 2'b10;
        haddr_i <= a;
        hwrite_i <= wr;
        do @(posedge mclk_i); while (hready_i !== 1'b1);
        htrans_i <= 2'b00;
        hwdata_i <= wd;
        do @(posedge mclk_i); while (hready_i !== 1'b1);
        rd = hrdata_o;
    endtask
    task automatic wait_en();
        do @(negedge mclk_i); while (cycle_en_o !== 1'b1);
    endtask
    task automatic exec(input logic [13:0] op, input logic [7:0] fd,
                        input logic [12:0] t);
        wait_en();
        @(posedge mclk_i);
        insn_i <= op;
        file_rdata_i <= fd;
        tos_i <= t;
        wait_en();
        @(posedge mclk_i);
        insn_i <= 14'h0000;
        @(negedge mclk_i);
    endtask
    task automatic t_rotate();
        logic [13:0] op [4] = '{14'h0CFF, 14'h0C00, 14'h0D01, 14'h0DFF};
        logic [7:0] fd [4] = '{8'hE6, 8'h01, 8'h66, 8'h80};
        logic c = 1'b0;
        logic [7:0] r;
        for (int i = 0; i < 4; i++) begin
            exec(op[i], fd[i], 13'h0);
            r = op[i][8] ? {fd[i][6:0], c} : {c, fd[i][7:1]};
            c = op[i][8] ? fd[i][7] : fd[i][0];
            chk("we", file_we_o, op[i][7]);
            if (op[i][7]) begin
                chk("wdata", file_wdata_o, r);
                chk("waddr", file_waddr_o, op[i][6:0]);
            end else chk("wreg", working_reg_o, r);
            chk("carry", carry_o, c);
        end
    endtask
    task automatic t_return();
        exec(OPC_RETURN, 8'h00, 13'h1ABC);
        chk("pop", stack_pop_o, 1);
        chk("pc", program_counter_o, 13'h1ABC);
        chk("carry", carry_o, 1);
        chk("busy", busy_o, 1);
        @(posedge mclk_i);
        insn_i <= 14'h0D01;
        file_rdata_i <= 8'hFF;
        wait_en();
        chk("raddr", file_raddr_o, 7'h01);
        @(posedge mclk_i);
        insn_i <= 14'h0000;
        @(negedge mclk_i);
        chk("flush", flush_o, 1);
        chk("wreg", working_reg_o, 8'hCD);
    endtask
    task automatic t_sleep();
        ahb(0, STATUS_ADDR, 0);
        chk("stat", rd[2:1], 2'b11);
        exec(OPC_SLEEP, 8'h00, 13'h0);
        chk("wdt", wdt_clear_o, 1);
        chk("flags", {sleep_o, timeout_flag_o, powerdown_flag_o}, 3'b110);
        exec(14'h0CFF, 8'h01, 13'h0);
        chk("halt", {sleep_o, file_we_o}, 2'b10);
        ahb(1, CTRL_ADDR, 32'h0000_0003);
        ahb(0, STATUS_ADDR, 0);
        chk("stat", rd, 32'h0000_000A);
        ahb(1, WREG_ADDR, 32'h0000_005A);
        ahb(0, WREG_ADDR, 0);
        chk("wreg", rd, 32'h0000_005A);
        ahb(0, 32'h0000_000C, 0);
        chk("unmapped", rd, 32'h0000_0000);
        chk("resp", hresp_o, 1'b0);
    endtask
    task automatic t_refuse();
        ahb(1, CTRL_ADDR, 32'h0000_0000);
        ahb(0, CTRL_ADDR, 0);
        chk("ctrl", rd, 32'h0000_0000);
        exec(14'h0DFF, 8'h01, 13'h0);
        chk("off", {file_we_o, carry_o}, 2'b01);
        ahb(1, CTRL_ADDR, 32'h0000_0001);
        ahb(0, CTRL_ADDR, 0);
        chk("ctrl", rd, 32'h0000_0001);
        @(posedge mclk_i);
        insn_valid_i <= 1'b0;
        exec(14'h0DFF, 8'h01, 13'h0);
        chk("invalid", {file_we_o, carry_o}, 2'b01);
        @(posedge mclk_i);
        insn_valid_i <= 1'b1;
        exec(14'h0DFF, 8'h01, 13'h0);
        chk("wdata", file_wdata_o, 8'h03);
        chk("carry", carry_o, 1'b0);
    endtask
    task automatic t_reset();
        @(posedge mclk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(negedge mclk_i);
        chk("rst_wreg", working_reg_o, 8'h00);
        chk("rst_flags", {sleep_o, timeout_flag_o, powerdown_flag_o,
            carry_o}, 4'h6);
        chk("rst_pc", program_counter_o, 13'h0000);
        chk("rst_busy", busy_o, 1'b0);
        exec(14'h0C85, 8'hE6, 13'h0);
        chk("we", file_we_o, 1'b1);
        chk("waddr", file_waddr_o, 7'h05);
        chk("wdata", file_wdata_o, 8'h73);
        chk("carry", carry_o, 1'b0);
    endtask

    initial begin
        repeat (12) @(posedge mclk_i);
        rst_i <= 1'b0;
        t_rotate();
        t_return();
        t_sleep();
        t_refuse();
        t_reset();
        wrap_up();
    end
    initial begin
        repeat (20000) @(posedge mclk_i);
        err_count++;
        wrap_up();
    end
endmodule // tb

bind return_rotate_sleep_exec rrs_checker #(.PC_W(PC_W)) u_chk (.*);
